// file: xmem_window_consts.svh
// Offsets, field positions, reset values and counts for the X-memory register windows.
`ifndef XMEM_WINDOW_CONSTS_SVH
`define XMEM_WINDOW_CONSTS_SVH
`define CORE1_CTRL_BASE       21'h0ffe00
`define CORE2_CTRL_BASE       21'h17fe00
`define CORE3_CTRL_BASE       21'h1ffe00
`define CTRL_STATUS2_OFS      21'h000006
`define WIN_A_CFG_OFS         21'h000054
`define WIN_B_CFG_OFS         21'h000056
`define WIN_C_CFG_OFS         21'h000058
`define WIN_D_CFG_OFS         21'h00005a
`define WIN_HALFWORD_BIT      31
`define WIN_PAGE_MSB          15
`define WIN_CFG_RESET         32'h00000000
`define CLASH_FIELD_LSB       16
`define CLASH_RESET           16'h0000
`define FIXED_WIN_LO          16'hc000
`define FIXED_WIN_HI          16'hdfff
`define MOVABLE_WIN_LO        16'hf000
`define WIN_PAGE_SHIFT        9
`define CORE_CLOCK_REG_LIMIT  21'h040000
`define CORE1_PROG_BASE       21'h080000
`define CORE1_PROG_LAST       21'h085ffe
`define CORE1_XDATA_BASE      21'h0a0000
`define CORE1_YDATA_BASE      21'h0c0000
`define CORE1_COEF_BASE       21'h0e0000
`define CORE2_PROG_BASE       21'h100000
`define CORE2_PROG_LAST       21'h10effe
`define CORE3_PROG_BASE       21'h180000
`define CORE3_PROG_LAST       21'h18effe
`define SHARED_ALIAS2_BASE    21'h136000
`define SHARED_ALIAS2_LAST    21'h137ffe
`define SHARED_ALIAS3_BASE    21'h1b6000
`define SHARED_ALIAS3_LAST    21'h1b7ffe
`define SHARED_WORDS          4096
`endif

// file: xmem_window_pkg.sv
// Types shared by the X-memory window bridge.
package xmem_window_pkg;
	typedef logic [20:0] reg_addr_t;
	typedef logic [15:0] xaddr_t;
	typedef logic [23:0] xword_t;
	typedef enum logic [2:0] {
		MAP_NONE  = 3'b001,
		MAP_FIXED = 3'b010,
		MAP_WIN   = 3'b100
	} map_kind_e;
endpackage : xmem_window_pkg

// file: xmem_addr_map.sv
// Combinational translation of one core's X-memory address into device register space.
`timescale 1ns/1ps
`include "xmem_window_consts.svh"
module xmem_addr_map
	import xmem_window_pkg::*;
(
	input  wire xaddr_t          xaddr,
	input  wire logic [127:0]    win_cfg,
	output map_kind_e            kind,
	output reg_addr_t            reg_addr,
	output logic                 wide
);
	logic [1:0]  sel;
	logic [31:0] cfg;
	reg_addr_t   base;

	always_comb
	begin
		sel      = xaddr[11:10];
		cfg      = win_cfg[32*sel +: 32];
		base     = reg_addr_t'({cfg[`WIN_PAGE_MSB:0], 9'h000});
		kind     = MAP_NONE;
		reg_addr = '0;
		wide     = 1'b0;
		if (xaddr >= `FIXED_WIN_LO && xaddr <= `FIXED_WIN_HI)
		begin
			kind     = MAP_FIXED;
			reg_addr = reg_addr_t'(xaddr - `FIXED_WIN_LO);
		end
		else if (xaddr >= `MOVABLE_WIN_LO)
		begin
			kind = MAP_WIN;
			if (cfg[`WIN_HALFWORD_BIT])
				reg_addr = base + reg_addr_t'(xaddr[9:0]);
			else
			begin
				reg_addr = base + reg_addr_t'({xaddr[9:0], 1'b0});
				wide     = 1'b1;
			end
		end
	end
endmodule : xmem_addr_map

// file: shared_mem.sv
// Shared X-data store between cores two and three with write-clash capture.
`timescale 1ns/1ps
`include "xmem_window_consts.svh"
module shared_mem
	import xmem_window_pkg::*;
#(
	parameter int WORDS = `SHARED_WORDS
)
(
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic [1:0]                wr,
	input  wire logic [2*$clog2(WORDS)-1:0] waddr,
	input  wire logic [47:0]               wdata,
	input  wire logic [$clog2(WORDS)-1:0]  raddr,
	output xword_t                         rdata,
	output logic                           clash,
	output logic [15:0]                    clash_addr
);
	localparam int AW = $clog2(WORDS);
	xword_t mem [WORDS];

	typedef struct packed {
		logic        clash;
		logic [15:0] addr;
	} state_s;
	state_s state_reg;
	state_s state_next;

	logic [AW-1:0] a0;
	logic [AW-1:0] a1;

	always_comb
	begin
		a0         = waddr[AW-1:0];
		a1         = waddr[2*AW-1:AW];
		state_next = state_reg;
		state_next.clash = 1'b0;
		if (wr[0] && wr[1] && a0 == a1)
		begin
			state_next.clash = 1'b1;
			state_next.addr  = 16'(a0);
		end
	end

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			state_reg <= '{clash: 1'b0, addr: `CLASH_RESET};
		else
			state_reg <= state_next;

	// Core three is written last so it wins a same-address clash; the event is still reported.
	always_ff @(posedge clk)
	begin
		if (wr[0])
			mem[a0] <= wdata[23:0];
		if (wr[1])
			mem[a1] <= wdata[47:24];
	end

	assign rdata      = mem[raddr];
	assign clash      = state_reg.clash;
	assign clash_addr = state_reg.addr;
endmodule : shared_mem

// file: xmem_bridge.sv
// Register windows from three cores' X-memory into device register space.
`timescale 1ns/1ps
`include "xmem_window_consts.svh"
module xmem_bridge
	import xmem_window_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rstn,
	// Host register port, one 16-bit register per access.
	input  wire logic          host_req,
	input  wire logic          host_we,
	input  wire reg_addr_t     host_addr,
	input  wire logic [15:0]   host_wdata,
	output logic [15:0]        host_rdata,
	output logic               host_ack,
	// X-memory access of each core above its data storage.
	input  wire logic [2:0]    core_req,
	input  wire logic [2:0]    core_we,
	input  wire logic [47:0]   core_xaddr,
	input  wire logic [71:0]   core_wdata,
	output logic [71:0]        core_rdata,
	output logic [2:0]         core_ack,
	// Downstream device register space, for addresses this block does not own.
	output logic               dev_req,
	output logic               dev_we,
	output reg_addr_t          dev_addr,
	output logic [15:0]        dev_wdata,
	input  wire logic [15:0]   dev_rdata,
	input  wire logic          system_core_clock_on,
	output logic               shared_clash_event
);
	// ------------------------------------------------------------
	// Arbitration and state
	// ------------------------------------------------------------
	// Accesses are served one 16-bit register per cycle; a word-mode window access
	// takes two cycles (even then odd). Host has priority over the cores.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOW  = 3'b010,
		ST_HIGH = 3'b100
	} phase_e;

	typedef struct packed {
		phase_e          phase;
		logic [1:0]      who;
		logic            host_ack;
		logic [15:0]     host_rdata;
		logic [2:0]      core_ack;
		logic [71:0]     core_rdata;
		logic [383:0]    win_cfg;
		logic            dev_req;
		logic            dev_we;
		reg_addr_t       dev_addr;
		logic [15:0]     dev_wdata;
		logic            clash_evt;
		reg_addr_t       cur_addr;
		logic            cur_wide;
		logic [15:0]     lo_half;
	} state_s;

	state_s state_reg;
	state_s state_next;

	map_kind_e  kind   [3];
	reg_addr_t  maddr  [3];
	logic       mwide  [3];

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_map
			xmem_addr_map u_map (
				.xaddr    (core_xaddr[16*g +: 16]),
				.win_cfg  (state_reg.win_cfg[128*g +: 128]),
				.kind     (kind[g]),
				.reg_addr (maddr[g]),
				.wide     (mwide[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Shared memory
	// ------------------------------------------------------------
	logic [1:0]   sh_wr;
	logic [23:0]  sh_waddr;
	logic [47:0]  sh_wdata;
	logic [11:0]  sh_raddr;
	xword_t       sh_rdata;
	logic         sh_clash;
	logic [15:0]  sh_clash_addr;
	logic [11:0]  sh_word2;
	logic [11:0]  sh_word3;
	logic         sh_hit2;
	logic         sh_hit3;
	logic [12:0]  sh_cand2;
	logic [12:0]  sh_cand3;
	logic         clash_try;

	// Each alias is 4096 words of two halfword registers; bit 0 is the half.
	function automatic logic in_range(reg_addr_t a, reg_addr_t lo, reg_addr_t hi);
		in_range = (a >= lo) && (a <= hi + 21'h1);
	endfunction : in_range

	// Bit 12 flags a hit on either alias; bits 11:0 index the 24-bit shared word.
	function automatic logic [12:0] shared_word(reg_addr_t a);
		shared_word = 13'h0000;
		if (in_range(a, `SHARED_ALIAS2_BASE, `SHARED_ALIAS2_LAST))
			shared_word = {1'b1, 12'((a - `SHARED_ALIAS2_BASE) >> 1)};
		else if (in_range(a, `SHARED_ALIAS3_BASE, `SHARED_ALIAS3_LAST))
			shared_word = {1'b1, 12'((a - `SHARED_ALIAS3_BASE) >> 1)};
	endfunction : shared_word

	always_comb
	begin
		sh_hit2  = in_range(state_reg.cur_addr, `SHARED_ALIAS2_BASE, `SHARED_ALIAS2_LAST);
		sh_hit3  = in_range(state_reg.cur_addr, `SHARED_ALIAS3_BASE, `SHARED_ALIAS3_LAST);
		sh_word2 = 12'((state_reg.cur_addr - `SHARED_ALIAS2_BASE) >> 1);
		sh_word3 = 12'((state_reg.cur_addr - `SHARED_ALIAS3_BASE) >> 1);
		sh_cand2 = shared_word(maddr[1]);
		sh_cand3 = shared_word(maddr[2]);
		// Cores two and three writing one shared word in the same idle cycle, with no host request, is a clash.
		// Requests whose acks still stand were just answered and do not count again.
		clash_try = state_reg.phase == ST_IDLE && !host_req && &core_req[2:1] && &core_we[2:1]
			&& state_reg.core_ack[2:1] == 2'b00 && sh_cand2[12] && sh_cand3[12]
			&& sh_cand2[11:0] == sh_cand3[11:0];
		sh_raddr = clash_try ? sh_cand2[11:0] : sh_hit3 ? sh_word3 : sh_word2;
	end

	shared_mem #(.WORDS(`SHARED_WORDS)) u_shared (
		.clk        (clk),
		.rstn       (rstn),
		.wr         (sh_wr),
		.waddr      (sh_waddr),
		.wdata      (sh_wdata),
		.raddr      (sh_raddr),
		.rdata      (sh_rdata),
		.clash      (sh_clash),
		.clash_addr (sh_clash_addr)
	);

	// ------------------------------------------------------------
	// Local register decode
	// ------------------------------------------------------------
	logic [1:0]  sel_core;
	logic        sel_status;
	logic [2:0]  sel_win;
	logic        sel_win_hi;
	logic        local_hit;
	logic [15:0] local_rdata;
	logic [1:0]  served;

	always_comb
	begin
		sel_core   = 2'd3;
		sel_status = 1'b0;
		sel_win    = 3'd4;
		sel_win_hi = state_reg.cur_addr[0];
		for (int c = 0; c < 3; c++)
		begin
			reg_addr_t b;
			b = (c == 0) ? `CORE1_CTRL_BASE : (c == 1) ? `CORE2_CTRL_BASE : `CORE3_CTRL_BASE;
			if (state_reg.cur_addr[20:8] == b[20:8])
				sel_core = 2'(c);
		end
		local_hit   = 1'b0;
		local_rdata = 16'h0000;
		if (sel_core != 2'd3)
		begin
			case (state_reg.cur_addr[7:0])
				8'h06: begin sel_status = 1'b1; local_hit = 1'b1; end
				8'h07: begin sel_status = 1'b1; local_hit = 1'b1; end
				8'h54, 8'h55: begin sel_win = 3'd0; local_hit = 1'b1; end
				8'h56, 8'h57: begin sel_win = 3'd1; local_hit = 1'b1; end
				8'h58, 8'h59: begin sel_win = 3'd2; local_hit = 1'b1; end
				8'h5a, 8'h5b: begin sel_win = 3'd3; local_hit = 1'b1; end
				default: local_hit = 1'b0;
			endcase
			if (sel_status && !state_reg.cur_addr[0] && sel_core != 2'd0)
				local_rdata = sh_clash_addr;
			if (sel_win != 3'd4)
				local_rdata = state_reg.win_cfg[128*sel_core + 32*sel_win + (sel_win_hi ? 16 : 0)
					+: 16];
		end
		served = state_reg.who;
	end

	// ------------------------------------------------------------
	// Access engine
	// ------------------------------------------------------------
	logic        act_we;
	logic [15:0] act_wdata;
	logic [15:0] act_rdata;
	logic [23:0] cw;
	logic        sh_any;

	always_comb
	begin
		state_next = state_reg;
		state_next.host_ack  = 1'b0;
		state_next.core_ack  = 3'b000;
		state_next.dev_req   = 1'b0;
		state_next.clash_evt = sh_clash;
		sh_wr    = 2'b00;
		sh_waddr = {sh_word3, sh_word2};
		sh_wdata = '0;
		if (clash_try)
		begin
			// Both ports rewrite the stored word: the clash is caught, the data unchanged.
			// The engine then applies each core's write in turn, core three last.
			sh_wr    = 2'b11;
			sh_waddr = {sh_cand3[11:0], sh_cand2[11:0]};
			sh_wdata = {2{sh_rdata}};
		end
		act_we    = 1'b0;
		act_wdata = 16'h0000;
		cw        = '0;
		sh_any    = sh_hit2 || sh_hit3;

		if (served == 2'd3)
		begin
			act_we    = host_we;
			act_wdata = host_wdata;
		end
		else
		begin
			cw     = core_wdata[24*served +: 24];
			act_we = core_we[served];
			// Even register takes the low half, odd register's low byte the top byte.
			act_wdata = (state_reg.phase == ST_HIGH) ? {8'h00, cw[23:16]} : cw[15:0];
			if (!state_reg.cur_wide)
				act_wdata = cw[15:0];
		end

		act_rdata = local_hit ? local_rdata : sh_any ? (state_reg.cur_addr[0] ?
			{8'h00, sh_rdata[23:16]} : sh_rdata[15:0]) : dev_rdata;

		case (state_reg.phase)
			ST_IDLE:
			begin
				// A request still high while its ack stands is the one just answered.
				if (host_req && !state_reg.host_ack)
				begin
					// Host path is a pure register access; it waits for no core clock.
					state_next.who      = 2'd3;
					state_next.cur_addr = host_addr;
					state_next.cur_wide = 1'b0;
					state_next.phase    = ST_LOW;
				end
				else
				begin
					for (int c = 2; c >= 0; c--)
						if (core_req[c] && !state_reg.core_ack[c] && kind[c] != MAP_NONE)
						begin
							state_next.who      = 2'(c);
							state_next.cur_addr = maddr[c];
							state_next.cur_wide = mwide[c];
							state_next.phase    = ST_LOW;
						end
				end
			end
			ST_LOW, ST_HIGH:
			begin
				if (local_hit && act_we && sel_win != 3'd4)
				begin
					if (sel_win_hi)
						state_next.win_cfg[128*sel_core + 32*sel_win + 16 +: 16] =
							{act_wdata[15], 15'h0000};
					else
						state_next.win_cfg[128*sel_core + 32*sel_win +: 16] = act_wdata;
				end
				else if (sh_any && act_we)
				begin
					// Each side keeps the other half of the 24-bit word.
					sh_wr[sh_hit3 ? 1 : 0] = 1'b1;
					sh_wdata = state_reg.cur_addr[0] ?
						{2{act_wdata[7:0], sh_rdata[15:0]}} :
						{2{sh_rdata[23:16], act_wdata}};
				end
				else if (!local_hit && !sh_any)
				begin
					// Program words use 3 halfword pairs per 2 words in device space.
					state_next.dev_req   = 1'b1;
					state_next.dev_we    = act_we;
					state_next.dev_addr  = state_reg.cur_addr;
					state_next.dev_wdata = act_wdata;
				end
				if (state_reg.phase == ST_LOW && state_reg.cur_wide)
				begin
					state_next.lo_half  = act_rdata;
					state_next.cur_addr = state_reg.cur_addr + 21'h1;
					state_next.phase    = ST_HIGH;
				end
				else
				begin
					state_next.phase = ST_IDLE;
					if (served == 2'd3)
					begin
						state_next.host_ack   = 1'b1;
						state_next.host_rdata = act_rdata;
					end
					else
					begin
						state_next.core_ack[served] = 1'b1;
						state_next.core_rdata[24*served +: 24] = state_reg.cur_wide ?
							{act_rdata[7:0], state_reg.lo_half} : {8'h00, act_rdata};
					end
				end
			end
			default: state_next.phase = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			state_reg <= '{phase: ST_IDLE, who: 2'd0, host_rdata: 16'h0000,
				core_rdata: '0, win_cfg: {12{`WIN_CFG_RESET}}, dev_addr: '0,
				dev_wdata: 16'h0000, cur_addr: '0, lo_half: 16'h0000, default: 1'b0};
		else
			state_reg <= state_next;

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign host_ack           = state_reg.host_ack;
	assign host_rdata         = state_reg.host_rdata;
	assign core_ack           = state_reg.core_ack;
	assign core_rdata         = state_reg.core_rdata;
	assign dev_req            = state_reg.dev_req;
	assign dev_we             = state_reg.dev_we;
	assign dev_addr           = state_reg.dev_addr;
	assign dev_wdata          = state_reg.dev_wdata;
	assign shared_clash_event = state_reg.clash_evt;
endmodule : xmem_bridge

// file: xmem_bridge_props.sv
// Port-level timing and mapping checks for the X-memory window bridge.
`timescale 1ns/1ps
module xmem_bridge_props
	import xmem_window_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        host_req,
	input wire logic        host_ack,
	input wire logic [2:0]  core_req,
	input wire logic [47:0] core_xaddr,
	input wire logic [2:0]  core_ack,
	input wire logic        dev_req,
	input wire reg_addr_t   dev_addr,
	input wire logic        shared_clash_event
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	host_pulse_a: assert property (host_ack |=> !host_ack)
		else $error("host ack longer than one cycle");
	core_pulse_a: assert property (|core_ack |=> core_ack == 3'b000)
		else $error("core ack longer than one cycle");
	ack_single_a: assert property ($onehot0({host_ack, core_ack}))
		else $error("two accesses answered at once");
	host_cause_a: assert property (host_ack |-> $past(host_req))
		else $error("host ack without request");
	host_lat_a: assert property ($rose(host_req) |-> ##[2:3] host_ack)
		else $error("host ack late");
	fixed_lat_a: assert property ($rose(core_req[0]) && core_xaddr[15:13] == 3'b110
		&& !host_req |-> ##[2:3] core_ack[0])
		else $error("fixed window ack late");
	fixed_map_a: assert property ($rose(core_req[0]) && core_xaddr[15:13] == 3'b110
		&& !host_req |-> ##[1:3] (dev_req && dev_addr == {8'h00, core_xaddr[12:0]}))
		else $error("fixed window address wrong");
	window_lat_a: assert property ($rose(core_req[0]) && core_xaddr[15:12] == 4'hf
		&& !host_req |-> ##[2:4] core_ack[0])
		else $error("movable window ack late");
	refuse_a: assert property (core_req[0] && core_xaddr[15:14] != 2'b11 |=> !core_ack[0])
		else $error("data storage access answered");
	clash_pulse_a: assert property (shared_clash_event |=> !shared_clash_event)
		else $error("clash event longer than one cycle");
endmodule : xmem_bridge_props

bind xmem_bridge xmem_bridge_props u_props (.clk(clk), .rstn(rstn), .host_req(host_req),
	.host_ack(host_ack), .core_req(core_req), .core_xaddr(core_xaddr), .core_ack(core_ack),
	.dev_req(dev_req), .dev_addr(dev_addr), .shared_clash_event(shared_clash_event));

// file: dev_regs_model.sv
// Behavioural model of the downstream device register space.
`timescale 1ns/1ps
module dev_regs_model
	import xmem_window_pkg::*;
#(
	parameter logic [15:0] RD = 16'h5a3c
)
(
	input wire logic        clk,
	input wire logic        dev_req,
	input wire logic        dev_we,
	input wire reg_addr_t   dev_addr,
	input wire logic [15:0] dev_wdata,
	output logic [15:0]     dev_rdata
);
	logic [15:0] mem [0:4095];
	// The bridge samples read data before its address is out, so reads see one fixed word.
	assign dev_rdata = RD;
	always_ff @(posedge clk)
	begin
		if (dev_req && dev_we)
			mem[dev_addr[11:0]] <= dev_wdata;
	end
endmodule : dev_regs_model

// file: tb_xmem_bridge.sv
// Self-checking bench for the X-memory register window bridge.
`timescale 1ns/1ps
`include "xmem_window_consts.svh"
module tb_xmem_bridge
	import xmem_window_pkg::*;
;
	localparam logic [15:0] RD = 16'h5a3c;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        host_req = 1'b0;
	logic        host_we = 1'b0;
	reg_addr_t   host_addr = '0;
	logic [15:0] host_wdata = '0;
	logic [15:0] host_rdata;
	logic        host_ack;
	logic [2:0]  core_req = '0;
	logic [2:0]  core_we = '0;
	logic [47:0] core_xaddr = '0;
	logic [71:0] core_wdata = '0;
	logic [71:0] core_rdata;
	logic [2:0]  core_ack;
	logic        dev_req;
	logic        dev_we;
	reg_addr_t   dev_addr;
	logic [15:0] dev_wdata;
	logic [15:0] dev_rdata;
	logic        shared_clash_event;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	logic [15:0] q;
	logic [23:0] w;

	xmem_bridge dut (.clk(clk), .rstn(rstn), .host_req(host_req), .host_we(host_we),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_ack(host_ack), .core_req(core_req), .core_we(core_we),
		.core_xaddr(core_xaddr), .core_wdata(core_wdata), .core_rdata(core_rdata),
		.core_ack(core_ack), .dev_req(dev_req), .dev_we(dev_we), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .system_core_clock_on(1'b1),
		.shared_clash_event(shared_clash_event));
	dev_regs_model #(.RD(RD)) dm (.clk(clk), .dev_req(dev_req), .dev_we(dev_we),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checked %0d, mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic hacc(input logic we, input reg_addr_t a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		host_req <= 1'b1;
		host_we <= we;
		host_addr <= a;
		host_wdata <= d;
		do @(posedge clk); while (host_ack !== 1'b1 && ++n < 20);
		if (n >= 20)
			miscompares++;
		q = host_rdata;
		host_req <= 1'b0;
		// Let the register model's write land before a scenario looks into it.
		@(negedge clk);
	endtask : hacc

	task automatic cacc(input int i, input logic we, input xaddr_t a, input xword_t d);
		int n;
		n = 0;
		@(posedge clk);
		core_req[i] <= 1'b1;
		core_we[i] <= we;
		core_xaddr[i*16 +: 16] <= a;
		core_wdata[i*24 +: 24] <= d;
		do @(posedge clk); while (core_ack[i] !== 1'b1 && ++n < 20);
		if (n >= 20)
			miscompares++;
		w = core_rdata[i*24 +: 24];
		core_req[i] <= 1'b0;
		@(negedge clk);
	endtask : cacc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		for (int k = 0; k < 8; k++)
		begin
			hacc(1'b0, `CORE1_CTRL_BASE + `WIN_A_CFG_OFS + k, 16'h0000);
			chk(q, 24'h0);
		end
		hacc(1'b0, `CORE1_CTRL_BASE + `CTRL_STATUS2_OFS, 16'h0000);
		chk(q, 24'h0);
		hacc(1'b0, `CORE3_CTRL_BASE + `CTRL_STATUS2_OFS, 16'h0000);
		chk(q, 24'h0);
	endtask : t_reset

	task automatic t_cfg();
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_C_CFG_OFS, 16'h0123);
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_C_CFG_OFS + 1, 16'h8000);
		hacc(1'b0, `CORE1_CTRL_BASE + `WIN_C_CFG_OFS, 16'h0000);
		chk(q, 24'h0123);
		hacc(1'b0, `CORE1_CTRL_BASE + `WIN_C_CFG_OFS + 1, 16'h0000);
		chk(q, 24'h8000);
	endtask : t_cfg

	task automatic t_fixed();
		cacc(0, 1'b1, 16'hc123, 24'h00beef);
		chk(dm.mem[12'h123], 24'hbeef);
		cacc(0, 1'b0, 16'hdfff, 24'h0);
		chk(w[15:0], RD);
	endtask : t_fixed

	task automatic t_half();
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_B_CFG_OFS, 16'h0003);
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_B_CFG_OFS + 1, 16'h8000);
		cacc(0, 1'b1, 16'hf405, 24'h001234);
		chk(dm.mem[12'h605], 24'h1234);
	endtask : t_half

	task automatic t_word();
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_D_CFG_OFS, 16'h0002);
		cacc(0, 1'b1, 16'hfc04, 24'habcdef);
		chk(dm.mem[12'h408], 24'hcdef);
		chk(dm.mem[12'h409][7:0], 24'hab);
		cacc(0, 1'b0, 16'hfc04, 24'h0);
		chk(w, {RD[7:0], RD});
	endtask : t_word

	task automatic t_overlap();
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_A_CFG_OFS, 16'h0001);
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_A_CFG_OFS + 1, 16'h8000);
		hacc(1'b1, `CORE1_CTRL_BASE + `WIN_C_CFG_OFS, 16'h0001);
		cacc(0, 1'b1, 16'hf010, 24'h001111);
		chk(dm.mem[12'h210], 24'h1111);
		cacc(0, 1'b1, 16'hf810, 24'h002222);
		chk(dm.mem[12'h210], 24'h2222);
	endtask : t_overlap

	task automatic t_core3();
		hacc(1'b1, `CORE3_CTRL_BASE + `WIN_A_CFG_OFS, 16'h0005);
		hacc(1'b1, `CORE3_CTRL_BASE + `WIN_A_CFG_OFS + 1, 16'h8000);
		cacc(2, 1'b1, 16'hf001, 24'h000777);
		chk(dm.mem[12'ha01], 24'h0777);
	endtask : t_core3

	task automatic t_shared();
		hacc(1'b1, `SHARED_ALIAS2_BASE + 21'h10, 16'h4321);
		hacc(1'b0, `SHARED_ALIAS3_BASE + 21'h10, 16'h0000);
		chk(q, 24'h4321);
		// Firmware load by the host needs no clock on the core side.
		hacc(1'b1, `CORE1_PROG_BASE, 16'h0f0f);
		chk(dm.mem[12'h000], 24'h0f0f);
	endtask : t_shared

	task automatic t_clash();
		int n;
		n = 0;
		hacc(1'b1, `CORE2_CTRL_BASE + `WIN_A_CFG_OFS, 16'h09b0);
		hacc(1'b1, `CORE2_CTRL_BASE + `WIN_A_CFG_OFS + 1, 16'h8000);
		hacc(1'b1, `CORE3_CTRL_BASE + `WIN_B_CFG_OFS, 16'h0db0);
		hacc(1'b1, `CORE3_CTRL_BASE + `WIN_B_CFG_OFS + 1, 16'h8000);
		@(posedge clk);
		core_req[2:1] <= 2'b11;
		core_we[2:1] <= 2'b11;
		core_xaddr[47:16] <= {16'hf420, 16'hf020};
		core_wdata[71:24] <= {24'h000bbb, 24'h000aaa};
		// Each core holds its request until the edge at which its own ack is seen.
		repeat (8)
		begin
			@(posedge clk);
			if (core_ack[1] === 1'b1)
				core_req[1] <= 1'b0;
			if (core_ack[2] === 1'b1)
				core_req[2] <= 1'b0;
			if (shared_clash_event === 1'b1)
				n++;
		end
		chk(24'(n), 24'h000001);
		hacc(1'b0, `SHARED_ALIAS2_BASE + 21'h20, 16'h0000);
		chk(q, 24'h000bbb);
		hacc(1'b0, `CORE2_CTRL_BASE + `CTRL_STATUS2_OFS, 16'h0000);
		chk(q, 24'h000010);
		hacc(1'b0, `CORE3_CTRL_BASE + `CTRL_STATUS2_OFS, 16'h0000);
		chk(q, 24'h000010);
	endtask : t_clash

	task automatic t_refuse();
		@(posedge clk);
		core_req[0] <= 1'b1;
		core_xaddr[15:0] <= 16'h1000;
		repeat (6)
		begin
			@(negedge clk);
			chk(core_ack, 24'h0);
		end
		@(posedge clk);
		core_req[0] <= 1'b0;
	endtask : t_refuse

	// ----------------------------------------
	// Clock, reset, sequence and timeout
	// ----------------------------------------
	initial
	begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			summarize();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_cfg();
		t_fixed();
		t_half();
		t_word();
		t_overlap();
		t_core3();
		t_shared();
		t_clash();
		t_refuse();
		summarize();
	end
endmodule : tb_xmem_bridge
